// ==== common/mct_chan_consts.svh ====
/*
 * offsets, field positions and reset values of the timer channel block.
 * assumes it is included by bare name, once per compilation unit or guarded.
 */
`ifndef MCT_CHAN_CONSTS_SVH
`define MCT_CHAN_CONSTS_SVH

// ----------------------------------------------------------------
// subaddress and subregister window
// ----------------------------------------------------------------
`define SUBADDR_STATUS 8'h01
`define SUBADDR_CHAN_A 8'h02
`define SUBADDR_CHAN_D 8'h05
`define SUBREG_0 2'h0
`define SUBREG_1 2'h1
`define SUBREG_2 2'h2

// ----------------------------------------------------------------
// control byte fields and reset values
// ----------------------------------------------------------------
`define CTL_ON_BIT 7
`define CTL_POL_BIT 6
`define CTL_IRQ_BIT 5
`define CTL_UPD_BIT 4
`define CTL_RSVD_MASK 8'hf7
`define CTL_RESET 8'h00
`define VALUE_RESET 16'h0000
`define FLAGS_RESET 4'h0

`endif

// ==== common/mct_chan_pkg.sv ====
/*
 * types shared by the timer channel block.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package mct_chan_pkg;

   // ----------------------------------------------------------------
   // channel method encodings
   // ----------------------------------------------------------------
   typedef enum logic [2:0]
   {
      METHOD_ONE_SHOT = 3'h0,
      METHOD_CONTINUOUS = 3'h1,
      METHOD_PWM = 3'h2,
      METHOD_CAPTURE = 3'h3
   } chan_method_type;

   typedef struct packed
   {
      logic chan_on;
      logic chan_polarity;
      logic chan_irq_on;
      logic chan_direct_update;
      logic rsvd;
      logic [2:0] chan_method;
   } chan_control_reg_type;

   // shared counter view handed in by the rest of the timer
   typedef struct packed
   {
      logic timer_run;
      logic count_down;
      logic updown_mode;
      logic end_of_count;
      logic [15:0] count;
   } timer_view_type;

endpackage

// ==== rtl/mct_channels.sv ====
/*
 * four capture/compare channels of a 16-bit multichannel timer, with their
 * event and overrun flags, reached through a subaddress/subregister byte window.
 * assumes the shared counter, prescaler and timer control live outside and
 * present the count, direction, mode, enable and a one-cycle end-of-count pulse
 * on i_clk; channel inputs are asynchronous pins.
 */
`include "mct_chan_consts.svh"

module mct_channels #(
   parameter int NUM_CHAN = 4
)(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [7:0] i_subaddr,
   input wire logic [1:0] i_subreg,
   input wire logic i_wr,
   input wire logic [7:0] i_wdata,
   output logic [7:0] o_rdata,
   input wire mct_chan_pkg::timer_view_type i_timer,
   input wire logic [NUM_CHAN-1:0] i_chan_in,
   output logic [NUM_CHAN-1:0] o_chan_out,
   output logic [NUM_CHAN-1:0] o_chan_irq,
   output logic o_any_channel_event
);

   // ----------------------------------------------------------------
   // register storage
   // ----------------------------------------------------------------
   mct_chan_pkg::chan_control_reg_type ctl_r [NUM_CHAN];
   logic [15:0] value_r [NUM_CHAN];
   logic [15:0] shadow_r [NUM_CHAN];
   logic [NUM_CHAN-1:0] pend_r;
   logic [NUM_CHAN-1:0] event_r;
   logic [NUM_CHAN-1:0] overrun_r;
   logic [NUM_CHAN-1:0] out_r;
   logic [NUM_CHAN-1:0] irq_r;
   logic [NUM_CHAN-1:0] seen_r;
   logic [NUM_CHAN-1:0] sync1_r;
   logic [NUM_CHAN-1:0] sync2_r;
   logic [NUM_CHAN-1:0] sync3_r;
   logic [NUM_CHAN-1:0] pin_r;
   logic [NUM_CHAN-1:0] hit;
   logic [NUM_CHAN-1:0] cap_edge;
   logic [NUM_CHAN-1:0] evt;
   logic [NUM_CHAN-1:0] clr;
   logic run;

   function automatic logic chan_sel(input logic [7:0] sa, input int c);
      return sa == (`SUBADDR_CHAN_A + 8'(c));
   endfunction

   assign run = i_timer.timer_run;
   assign clr = (i_wr && i_subaddr == `SUBADDR_STATUS && i_subreg == `SUBREG_1) ?
                i_wdata[NUM_CHAN-1:0] : '0;

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   // a level counts only once the second and third stages agree
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         sync1_r <= '0;
         sync2_r <= '0;
         sync3_r <= '0;
         pin_r <= '0;
      end
      else
      begin
         sync1_r <= i_chan_in;
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
         for (int c = 0; c < NUM_CHAN; c++)
         begin
            if (sync2_r[c] == sync3_r[c])
            begin
               pin_r[c] <= sync3_r[c];
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // event detection
   // ----------------------------------------------------------------
   always_comb
   begin
      for (int c = 0; c < NUM_CHAN; c++)
      begin
         // a held count would match every clock; seen_r keeps it to one event per arrival
         hit[c] = run && ctl_r[c].chan_on && !seen_r[c] &&
                  i_timer.count == value_r[c];
         cap_edge[c] = run && ctl_r[c].chan_on &&
                       (sync2_r[c] == sync3_r[c]) && (sync3_r[c] != pin_r[c]) &&
                       (sync3_r[c] == !ctl_r[c].chan_polarity);
         unique case (ctl_r[c].chan_method)
            mct_chan_pkg::METHOD_ONE_SHOT,
            mct_chan_pkg::METHOD_CONTINUOUS,
            mct_chan_pkg::METHOD_PWM: evt[c] = hit[c];
            mct_chan_pkg::METHOD_CAPTURE: evt[c] = cap_edge[c];
            default: evt[c] = 1'b0; // reserved codes raise nothing
         endcase
      end
   end

   // ----------------------------------------------------------------
   // event and overrun flags, interrupt requests
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         event_r <= `FLAGS_RESET;
         overrun_r <= `FLAGS_RESET;
         irq_r <= '0;
         seen_r <= '0;
      end
      else if (!run)
      begin
         event_r <= `FLAGS_RESET;
         overrun_r <= `FLAGS_RESET;
         irq_r <= '0;
         seen_r <= '0;
      end
      else
      begin
         for (int c = 0; c < NUM_CHAN; c++)
         begin
            seen_r[c] <= i_timer.count == value_r[c];
            irq_r[c] <= evt[c] && ctl_r[c].chan_irq_on;
            // a new event wins over a clear written in the same cycle
            event_r[c] <= evt[c] || (event_r[c] && !clr[c]);
            if (evt[c] && event_r[c] && !clr[c])
            begin
               overrun_r[c] <= 1'b1;
            end
            else if (clr[c])
            begin
               overrun_r[c] <= 1'b0;
            end
         end
      end
   end

   assign o_any_channel_event = |event_r;

   assign o_chan_irq = irq_r;

   // ----------------------------------------------------------------
   // control registers
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         for (int c = 0; c < NUM_CHAN; c++)
         begin
            ctl_r[c] <= `CTL_RESET;
         end
      end
      else
      begin
         for (int c = 0; c < NUM_CHAN; c++)
         begin
            if (i_wr && chan_sel(i_subaddr, c) && i_subreg == `SUBREG_2)
            begin
               ctl_r[c] <= i_wdata & `CTL_RSVD_MASK;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // channel values, write buffering and capture
   // ----------------------------------------------------------------
   // the shadow collects both bytes so a buffered pair lands together
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         pend_r <= '0;
         for (int c = 0; c < NUM_CHAN; c++)
         begin
            value_r[c] <= `VALUE_RESET;
            shadow_r[c] <= `VALUE_RESET;
         end
      end
      else
      begin
         for (int c = 0; c < NUM_CHAN; c++)
         begin
            logic wr_hi;
            logic wr_lo;
            logic [15:0] nxt;
            wr_hi = i_wr && chan_sel(i_subaddr, c) && i_subreg == `SUBREG_0;
            wr_lo = i_wr && chan_sel(i_subaddr, c) && i_subreg == `SUBREG_1;
            nxt = shadow_r[c];
            if (wr_hi)
            begin
               nxt[15:8] = i_wdata;
            end
            if (wr_lo)
            begin
               nxt[7:0] = i_wdata;
            end
            shadow_r[c] <= nxt;
            if (wr_hi || wr_lo)
            begin
               if (!run || ctl_r[c].chan_direct_update)
               begin
                  value_r[c] <= nxt;
                  pend_r[c] <= 1'b0;
               end
               else
               begin
                  pend_r[c] <= 1'b1;
               end
            end
            else if (pend_r[c] && (i_timer.end_of_count || !run))
            begin
               value_r[c] <= shadow_r[c];
               pend_r[c] <= 1'b0;
            end
            else if (cap_edge[c] && ctl_r[c].chan_method == mct_chan_pkg::METHOD_CAPTURE)
            begin
               value_r[c] <= i_timer.count;
               shadow_r[c] <= i_timer.count;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // channel outputs
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         out_r <= '0;
      end
      else
      begin
         for (int c = 0; c < NUM_CHAN; c++)
         begin
            unique case (ctl_r[c].chan_method)
               mct_chan_pkg::METHOD_ONE_SHOT:
               begin
                  out_r[c] <= ctl_r[c].chan_polarity ^ hit[c];
               end
               mct_chan_pkg::METHOD_CONTINUOUS:
               begin
                  if (!ctl_r[c].chan_on)
                  begin
                     out_r[c] <= ctl_r[c].chan_polarity;
                  end
                  else if (hit[c])
                  begin
                     out_r[c] <= !out_r[c];
                  end
               end
               mct_chan_pkg::METHOD_PWM:
               begin
                  // polarity has no effect in this method
                  if (!ctl_r[c].chan_on)
                  begin
                     out_r[c] <= 1'b0;
                  end
                  else if (hit[c])
                  begin
                     // up/down mode goes low on a match while counting down
                     out_r[c] <= !(i_timer.updown_mode && i_timer.count_down);
                  end
                  else if (!i_timer.updown_mode && run && i_timer.end_of_count)
                  begin
                     out_r[c] <= 1'b0;
                  end
               end
               default:
               begin
                  out_r[c] <= 1'b0;
               end
            endcase
         end
      end
   end

   assign o_chan_out = out_r;

   // ----------------------------------------------------------------
   // read data
   // ----------------------------------------------------------------
   always_comb
   begin
      o_rdata = 8'h00;
      if (i_subaddr == `SUBADDR_STATUS && i_subreg == `SUBREG_0)
      begin
         o_rdata = 8'(overrun_r);
      end
      else if (i_subaddr == `SUBADDR_STATUS && i_subreg == `SUBREG_1)
      begin
         o_rdata = 8'(event_r);
      end
      for (int c = 0; c < NUM_CHAN; c++)
      begin
         if (chan_sel(i_subaddr, c))
         begin
            unique case (i_subreg)
               `SUBREG_0: o_rdata = value_r[c][15:8];
               `SUBREG_1: o_rdata = value_r[c][7:0];
               `SUBREG_2: o_rdata = ctl_r[c];
               default: o_rdata = 8'h00;
            endcase
         end
      end
   end

endmodule

// ==== verification/mct_channels_properties.sv ====
/* port-level checks of the timer channel block.
   assumes one clock, i_rst asynchronous and active high. */
module mct_channels_properties #(
   parameter int NUM_CHAN = 4
)(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [7:0] i_subaddr,
   input wire logic [1:0] i_subreg,
   input wire logic i_wr,
   input wire logic [7:0] i_wdata,
   input wire logic [7:0] o_rdata,
   input wire mct_chan_pkg::timer_view_type i_timer,
   input wire logic [NUM_CHAN-1:0] i_chan_in,
   input wire logic [NUM_CHAN-1:0] o_chan_out,
   input wire logic [NUM_CHAN-1:0] o_chan_irq,
   input wire logic o_any_channel_event
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge i_clk);
   endclocking
   default disable iff (i_rst);

   // ------
   // flags, interrupts and register writes
   // ------
   a_flags_off: assert property (
      !i_timer.timer_run ##1 (!i_timer.timer_run && i_subaddr == 8'h01) |-> o_rdata == 8'h00)
      else $error("status flags set while timer stopped");
   a_summary_off: assert property (
      !i_timer.timer_run ##1 !i_timer.timer_run |-> !o_any_channel_event)
      else $error("summary set while timer stopped");
   a_summary_match: assert property (
      i_subaddr == 8'h01 && i_subreg == 2'h1 |-> o_rdata[7:4] == 4'h0 && o_any_channel_event == |o_rdata[3:0])
      else $error("summary differs from event flags");
   a_irq_flag: assert property (
      o_chan_irq != '0 |-> o_any_channel_event)
      else $error("interrupt without event flag");
   a_irq_run: assert property (
      o_chan_irq != '0 |-> $past(i_timer.timer_run))
      else $error("interrupt while timer stopped");
   a_irq_pulse: assert property (
      o_chan_irq != '0 |=> (o_chan_irq & $past(o_chan_irq)) == '0)
      else $error("interrupt longer than one cycle");
   a_value_direct: assert property (
      i_wr && !i_timer.timer_run && i_subaddr inside {[8'h02:8'h05]} && i_subreg < 2'h2
      ##1 $stable(i_subaddr) && $stable(i_subreg) |-> o_rdata == $past(i_wdata))
      else $error("value write not applied at once");
   a_control_write: assert property (
      i_wr && i_subaddr inside {[8'h02:8'h05]} && i_subreg == 2'h2
      ##1 $stable(i_subaddr) && $stable(i_subreg) |-> o_rdata == ($past(i_wdata) & 8'hf7))
      else $error("control write not applied");
endmodule

bind mct_channels mct_channels_properties #(.NUM_CHAN(NUM_CHAN)) props (.i_clk(i_clk), .i_rst(i_rst),
   .i_subaddr(i_subaddr), .i_subreg(i_subreg), .i_wr(i_wr), .i_wdata(i_wdata), .o_rdata(o_rdata),
   .i_timer(i_timer), .i_chan_in(i_chan_in), .o_chan_out(o_chan_out), .o_chan_irq(o_chan_irq),
   .o_any_channel_event(o_any_channel_event));

// ==== verification/pin_model.sv ====
/* channel input pins driven from outside: each follows the asked level at once,
   or two clocks late where slow is set.
   assumes i_clk is the block's system clock. */
module pin_model (
   input wire logic i_clk,
   input wire logic [3:0] i_req,
   input wire logic [3:0] i_slow,
   output logic [3:0] o_pins
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [3:0] d1_r, d2_r;

   always @(posedge i_clk)
   begin
      d1_r <= i_req;
      d2_r <= d1_r;
   end
   assign o_pins = (i_slow & d2_r) | (~i_slow & i_req);
endmodule

// ==== verification/testbench.sv ====
/* self-checking bench of the timer channel block: registers, compares, capture,
   buffered update and flag clearing.
   assumes pin_model drives the channel pins; the bench plays the shared counter. */
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic i_clk, i_rst, i_wr, o_any_channel_event;
   logic [7:0] i_subaddr, i_wdata, o_rdata;
   logic [1:0] i_subreg;
   logic [3:0] pin_req, pin_slow, i_chan_in, o_chan_out, o_chan_irq;
   logic [3:0] irq_q[$];
   logic [15:0] v;
   int n_errors = 0;
   int n_tests = 0;
   mct_chan_pkg::timer_view_type i_timer;

   mct_channels uut (.i_clk(i_clk), .i_rst(i_rst), .i_subaddr(i_subaddr), .i_subreg(i_subreg), .i_wr(i_wr),
      .i_wdata(i_wdata), .o_rdata(o_rdata), .i_timer(i_timer), .i_chan_in(i_chan_in), .o_chan_out(o_chan_out),
      .o_chan_irq(o_chan_irq), .o_any_channel_event(o_any_channel_event));
   pin_model pins (.i_clk(i_clk), .i_req(pin_req), .i_slow(pin_slow), .o_pins(i_chan_in));

   initial
   begin
      i_clk = 1'b0;
      forever #12.5 i_clk = ~i_clk;
   end

   // ------
   // tasks
   // ------
   task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_tests++;
      if (g !== e)
      begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_pins(input string nm, input logic [3:0] e, input logic [3:0] g);
      n_tests++;
      if (g !== e)
      begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [1:0] s, input logic [7:0] d);
      @(negedge i_clk);
      i_subaddr = a;
      i_subreg = s;
      i_wdata = d;
      i_wr = 1'b1;
      @(negedge i_clk);
      i_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [1:0] s, input logic [7:0] e, input string nm);
      @(negedge i_clk);
      i_subaddr = a;
      i_subreg = s;
      #2;
      chk_byte(nm, e, o_rdata);
   endtask
   task automatic cfg(input int ch, input logic [7:0] ctl, input logic [15:0] val);
      wr(8'(ch + 2), 2'h0, val[15:8]);
      wr(8'(ch + 2), 2'h1, val[7:0]);
      wr(8'(ch + 2), 2'h2, ctl);
   endtask
   // count sits on the value for one cycle, then moves on so the compare rearms
   task automatic hit(input logic [15:0] c);
      @(negedge i_clk);
      i_timer.count = c;
      @(negedge i_clk);
      i_timer.count = c + 16'h1;
   endtask
   task automatic eoc();
      @(negedge i_clk);
      i_timer.end_of_count = 1'b1;
      @(negedge i_clk);
      i_timer.end_of_count = 1'b0;
   endtask
   task automatic drain();
      for (int i = 0; i < 20 && irq_q.size() != 0; i++)
      begin
         @(negedge i_clk);
         #1;
      end
      if (irq_q.size() != 0)
      begin
         n_errors++;
         $display("mismatch irq_wait expected 0 seen %0d", irq_q.size());
         tally_and_finish();
      end
   endtask

   always @(negedge i_clk)
      if (o_chan_irq !== 4'h0)
         chk_pins("irq", (irq_q.size() != 0) ? irq_q.pop_front() : 4'h0, o_chan_irq);

   // ---------
   // stimulus
   // ---------
   initial
   begin
      i_rst = 1'b1;
      i_wr = 1'b0;
      i_subaddr = 8'h00;
      i_subreg = 2'h0;
      i_wdata = 8'h00;
      i_timer = '0;
      pin_req = 4'h0;
      pin_slow = 4'h0;
      void'($urandom(43));
      repeat (12) @(posedge i_clk);
      @(negedge i_clk);
      i_rst = 1'b0;
      for (int a = 1; a < 7; a++)
         for (int s = 0; s < 3; s++)
            rd(8'(a), 2'(s), 8'h00, "reset_value");
      v = 16'($urandom());
      cfg(3, {v[7:4], 2'h2, v[1:0]}, v);
      rd(8'h05, 2'h0, v[15:8], "value_high");
      rd(8'h05, 2'h1, v[7:0], "value_low");
      rd(8'h05, 2'h2, {v[7:4], 2'h0, v[1:0]}, "control");
      cfg(3, 8'h00, 16'h0000);
      $display("test registers done");
      // low byte kept below 80h so the count after a match never lands on channel b's value
      v = {8'h01, 1'b0, 7'($urandom())};
      cfg(1, 8'h81, 16'h0200);
      cfg(2, 8'ha3, 16'h0000);
      cfg(0, 8'h61, v);
      // the output follows a control write one clock after the register takes it
      @(negedge i_clk);
      chk_pins("outputs", 4'h1, o_chan_out & 4'h9);
      wr(8'h02, 2'h2, 8'he1);
      i_timer.timer_run = 1'b1;
      irq_q.push_back(4'h1);
      hit(v);
      chk_pins("outputs", 4'h0, o_chan_out & 4'h9);
      irq_q.push_back(4'h1);
      hit(v);
      chk_pins("outputs", 4'h1, o_chan_out & 4'h9);
      wr(8'h01, 2'h0, 8'h00);
      rd(8'h01, 2'h0, 8'h01, "overrun");
      wr(8'h01, 2'h1, 8'h0e);
      rd(8'h01, 2'h1, 8'h01, "events");
      wr(8'h01, 2'h1, 8'h01);
      rd(8'h01, 2'h1, 8'h00, "events");
      rd(8'h01, 2'h0, 8'h00, "overrun");
      hit(16'h0200);
      rd(8'h01, 2'h1, 8'h02, "events");
      $display("test compare flags done");
      @(negedge i_clk);
      i_timer.count = 16'h1234;
      irq_q.push_back(4'h4);
      pin_req[2] = 1'b1;
      drain();
      rd(8'h04, 2'h0, 8'h12, "capture_high");
      rd(8'h04, 2'h1, 8'h34, "capture_low");
      wr(8'h04, 2'h2, 8'he3);
      i_timer.count = 16'h5678;
      pin_slow[2] = 1'b1;
      irq_q.push_back(4'h4);
      pin_req[2] = 1'b0;
      drain();
      rd(8'h04, 2'h0, 8'h56, "capture_high");
      rd(8'h04, 2'h1, 8'h78, "capture_low");
      wr(8'h01, 2'h1, 8'h0f);
      $display("test capture done");
      wr(8'h05, 2'h0, 8'hab);
      rd(8'h05, 2'h0, 8'h00, "buffered");
      eoc();
      rd(8'h05, 2'h0, 8'hab, "applied");
      wr(8'h05, 2'h2, 8'h50);
      wr(8'h05, 2'h0, 8'h03);
      rd(8'h05, 2'h0, 8'h03, "direct");
      chk_pins("outputs", 4'h9, o_chan_out & 4'h9);
      wr(8'h05, 2'h2, 8'hd0);
      hit(16'h0300);
      chk_pins("outputs", 4'h1, o_chan_out & 4'h9);
      @(negedge i_clk);
      chk_pins("outputs", 4'h9, o_chan_out & 4'h9);
      wr(8'h05, 2'h2, 8'h12);
      @(negedge i_clk);
      chk_pins("outputs", 4'h1, o_chan_out & 4'h9);
      wr(8'h05, 2'h2, 8'h92);
      hit(16'h0300);
      chk_pins("outputs", 4'h9, o_chan_out & 4'h9);
      eoc();
      chk_pins("outputs", 4'h1, o_chan_out & 4'h9);
      i_timer.updown_mode = 1'b1;
      hit(16'h0300);
      chk_pins("outputs", 4'h9, o_chan_out & 4'h9);
      i_timer.count_down = 1'b1;
      hit(16'h0300);
      chk_pins("outputs", 4'h1, o_chan_out & 4'h9);
      $display("test output methods done");
      wr(8'h01, 2'h1, 8'h0f);
      wr(8'h02, 2'h2, 8'h21);
      hit(v);
      rd(8'h01, 2'h1, 8'h00, "events");
      hit(16'h0200);
      i_timer.timer_run = 1'b0;
      rd(8'h01, 2'h1, 8'h00, "events_off");
      $display("test disable done");
      chk_byte("irq_left", 8'h00, 8'(irq_q.size()));
      tally_and_finish();
   end
endmodule
